/* logic/mpu_top.v */
// Match based modulator unit: prescaled counter, seven matches, six outputs
//
// Local design decisions: the address map and the plain strobed port.
`default_nettype none
`include "mpu_map.vh"

module mpu_top (
  input  wire        core_clk,
  input  wire        srst,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire [1:0]  cap_in,
  input  wire        sync_in,
  output reg         sync_out,
  output reg  [5:0]  pwm_out,
  output reg         irq
);

  // Decode a match register address into its index, or 7 for none
  function [2:0] mpu_match_idx;
    input [7:0] addr;
    begin
      if (addr >= `MPU_OFF_MATCH_BASE && addr <= `MPU_OFF_MATCH_LAST && addr[1:0] == 2'b00) begin
        mpu_match_idx = addr[4:2] + 3'd0;
      end else begin
        mpu_match_idx = 3'd7;
      end
    end
  endfunction

  // Control and configuration state
  reg  [5:0]  ctrl;            // Enable, reset, mode and select bits
  reg  [31:0] count;           // Main counter
  reg  [31:0] prescale;        // Prescaler limit
  reg  [6:0]  mc_int;          // Interrupt on match
  reg  [6:0]  mc_rst;          // Reset counter on match
  reg  [6:0]  mc_stop;         // Stop counter on match
  reg  [5:0]  edge_sel;        // Double edge select, outputs 1 to 5 only
  reg  [5:0]  out_en;          // Output enable per output
  reg  [6:0]  release_pend;    // Released values waiting to be applied
  reg  [6:0]  int_status;      // Sticky match events
  reg  [6:0]  int_mask;        // Interrupt mask
  reg  [5:0]  pwm_level;       // Internal output levels
  reg  [1:0]  cap_prev;        // Capture inputs one cycle ago

  // Match storage: written values and values in use
  reg  [31:0] match_shadow [0:6];
  reg  [31:0] match_active [0:6];

  // Derived strobes
  wire [2:0]  wr_idx;          // Match index of a write
  wire [2:0]  rd_idx;          // Match index of a read
  wire        run;             // Counter may advance
  wire        cnt_clear;       // Counter held in reset
  wire        pwm_mode;        // Modulation enabled
  wire        cap_edge;        // Rising edge on selected capture input
  wire        src_event;       // One count source event
  wire        tick;            // Prescaled increment
  wire [31:0] presc_count;     // Prescaler state for readback
  wire [6:0]  hit;             // Match events this cycle
  wire        reset_hit;       // Some match resets the counter
  wire        stop_hit;        // Some match stops the counter
  wire        apply;           // Moment to copy released values
  wire [6:0]  applied;         // Matches copied this cycle
  wire [5:0]  next_pwm;        // Next output levels
  wire        rd_status;       // Read of the status word

  // Address decode: match index and status read strobe
  assign wr_idx    = mpu_match_idx(reg_addr);
  assign rd_idx    = mpu_match_idx(reg_addr);
  assign pwm_mode  = ctrl[`MPU_CTRL_PWM];
  assign cnt_clear = ctrl[`MPU_CTRL_CRST];
  assign rd_status = reg_rd && (reg_addr == `MPU_OFF_INT_STATUS);

  // Secondary follows the primary's registered enable on sync_in
  assign run = ctrl[`MPU_CTRL_FOLLOW] ? (sync_in & ctrl[`MPU_CTRL_EN]) : sync_out;

  // Count source: every clock, or rising edges of one capture input
  assign cap_edge  = cap_in[ctrl[`MPU_CTRL_CAP_SEL]] & ~cap_prev[ctrl[`MPU_CTRL_CAP_SEL]];
  assign src_event = ctrl[`MPU_CTRL_CNT_MODE] ? cap_edge : 1'b1;

  // Prescaler dividing the selected source
  mpu_prescaler u_presc (
    .core_clk    (core_clk),
    .srst        (srst),
    .run         (run),
    .clear       (cnt_clear),
    .src_event   (src_event),
    .limit       (prescale),
    .tick        (tick),
    .presc_count (presc_count)
  );

  // Compare every match against the counter on each tick
  // One generate index serves both loops below
  genvar gi;
  generate
    for (gi = 0; gi < `MPU_N_MATCH; gi = gi + 1) begin : g_cmp
      assign hit[gi] = tick & (count == match_active[gi]);
      assign applied[gi] = apply & release_pend[gi];
    end
  endgenerate

  // Match zero always restarts the period in modulation mode
  assign reset_hit = (|(hit & mc_rst)) | (pwm_mode & hit[0]);
  assign stop_hit  = |(hit & mc_stop);

  // Released values take effect at period start or while stopped, at once as a timer
  assign apply = pwm_mode ? (hit[0] | ~run) : 1'b1;

  // Output channels: single uses match 0 and its own, double its pair
  generate
    for (gi = 0; gi < `MPU_N_OUT; gi = gi + 1) begin : g_chan
      mpu_pwm_chan u_chan (
        .level      (pwm_level[gi]),
        .dbl        (edge_sel[gi] & (gi != 0)),
        .period_hit (hit[0]),
        .set_hit    (hit[gi]),
        .clr_hit    (hit[gi+1]),
        .next_level (next_pwm[gi])
      );
    end
  endgenerate

  // Capture history for edge detection
  always @(posedge core_clk) begin
    if (srst) begin
      cap_prev <= 2'b00;
    end else begin
      cap_prev <= cap_in;
    end
  end

  // Control word: software writes, hardware stop clears enable
  always @(posedge core_clk) begin
    if (srst) begin
      ctrl <= `MPU_RST_CTRL;
    end else begin
      if (reg_wr && reg_addr == `MPU_OFF_CTRL) begin
        ctrl <= reg_wdata[`MPU_CTRL_W-1:0];
      end
      // Stop on match wins over a simultaneous write
      if (stop_hit) begin
        ctrl[`MPU_CTRL_EN] <= 1'b0;
      end
    end
  end

  // Registered enable, also the start signal to a secondary unit
  always @(posedge core_clk) begin
    if (srst) begin
      sync_out <= 1'b0;
    end else begin
      sync_out <= ctrl[`MPU_CTRL_EN] & ~stop_hit;
    end
  end

  // Main counter: reset, hold or advance on tick
  always @(posedge core_clk) begin
    if (srst || cnt_clear) begin
      count <= `MPU_RST_WORD;
    end else if (tick) begin
      if (reset_hit) begin
        count <= `MPU_RST_WORD;
      end else begin
        count <= count + 32'h0000_0001;
      end
    end
  end

  // Plain configuration registers
  always @(posedge core_clk) begin
    if (srst) begin
      prescale <= `MPU_RST_WORD;
      mc_int   <= `MPU_RST_BITS7;
      mc_rst   <= `MPU_RST_BITS7;
      mc_stop  <= `MPU_RST_BITS7;
      edge_sel <= `MPU_RST_BITS6;
      out_en   <= `MPU_RST_BITS6;
      int_mask <= `MPU_RST_BITS7;
    end else if (reg_wr) begin
      case (reg_addr)
        `MPU_OFF_PRESCALE: begin
          prescale <= reg_wdata;
        end
        `MPU_OFF_MATCH_CTRL: begin
          mc_int  <= reg_wdata[`MPU_MC_INT_LSB+6:`MPU_MC_INT_LSB];
          mc_rst  <= reg_wdata[`MPU_MC_RST_LSB+6:`MPU_MC_RST_LSB];
          mc_stop <= reg_wdata[`MPU_MC_STOP_LSB+6:`MPU_MC_STOP_LSB];
        end
        `MPU_OFF_EDGE_SEL: begin
          edge_sel <= reg_wdata[5:0];
        end
        `MPU_OFF_OUT_EN: begin
          out_en <= reg_wdata[5:0];
        end
        `MPU_OFF_INT_MASK: begin
          int_mask <= reg_wdata[6:0];
        end
        default: begin
          // Other addresses hold nothing here
        end
      endcase
    end
  end

  // Loop indices, one per clocked process so neither has two drivers
  integer mi;                  // Index of the shadow process
  integer mj;                  // Index of the active-value process

  // Shadow match storage, written by software only
  always @(posedge core_clk) begin
    if (srst) begin
      for (mi = 0; mi < `MPU_N_MATCH; mi = mi + 1) begin
        match_shadow[mi] <= `MPU_RST_WORD;
      end
    end else if (reg_wr && wr_idx != 3'd7) begin
      match_shadow[wr_idx] <= reg_wdata;
    end
  end

  // Active match values, copied from shadow once released
  always @(posedge core_clk) begin
    if (srst) begin
      for (mj = 0; mj < `MPU_N_MATCH; mj = mj + 1) begin
        match_active[mj] <= `MPU_RST_WORD;
      end
    end else begin
      for (mj = 0; mj < `MPU_N_MATCH; mj = mj + 1) begin
        if (applied[mj]) begin
          match_active[mj] <= match_shadow[mj];
        end
      end
    end
  end

  // Release flags: a new release wins over the clear on apply
  always @(posedge core_clk) begin
    if (srst) begin
      release_pend <= `MPU_RST_BITS7;
    end else begin
      release_pend <= (release_pend & ~applied) |
                      ((reg_wr && reg_addr == `MPU_OFF_RELEASE) ? reg_wdata[6:0] : 7'h00);
    end
  end

  // Sticky match events; a new event wins over the read clear
  always @(posedge core_clk) begin
    if (srst) begin
      int_status <= `MPU_RST_BITS7;
    end else begin
      int_status <= (int_status & ~(rd_status ? 7'h7F : 7'h00)) | (hit & mc_int);
    end
  end

  // Level interrupt while an unmasked event is pending
  always @(posedge core_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((int_status & ~(rd_status ? 7'h7F : 7'h00)) | (hit & mc_int)) & int_mask);
    end
  end

  // Output levels, kept low unless modulation mode is on
  always @(posedge core_clk) begin
    if (srst || !pwm_mode) begin
      pwm_level <= `MPU_RST_BITS6;
      pwm_out   <= `MPU_RST_BITS6;
    end else begin
      pwm_level <= next_pwm;
      pwm_out   <= next_pwm & out_en;
    end
  end

  // Read data, valid in the cycle after the read strobe
  always @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= `MPU_RST_WORD;
    end else if (reg_rd) begin
      case (reg_addr)
        `MPU_OFF_CTRL: begin
          reg_rdata <= {26'h000_0000, ctrl};
        end
        `MPU_OFF_INT_STATUS: begin
          reg_rdata <= {25'h000_0000, int_status};
        end
        `MPU_OFF_INT_MASK: begin
          reg_rdata <= {25'h000_0000, int_mask};
        end
        `MPU_OFF_COUNT: begin
          reg_rdata <= count;
        end
        `MPU_OFF_PRESCALE: begin
          reg_rdata <= prescale;
        end
        `MPU_OFF_PRESC_COUNT: begin
          reg_rdata <= presc_count;
        end
        `MPU_OFF_MATCH_CTRL: begin
          reg_rdata <= {9'h000, mc_stop, 1'b0, mc_rst, 1'b0, mc_int};
        end
        `MPU_OFF_EDGE_SEL: begin
          reg_rdata <= {26'h000_0000, edge_sel};
        end
        `MPU_OFF_OUT_EN: begin
          reg_rdata <= {26'h000_0000, out_en};
        end
        `MPU_OFF_RELEASE: begin
          reg_rdata <= {25'h000_0000, release_pend};
        end
        default: begin
          // Match words read the shadow; unmapped reads zero
          reg_rdata <= (rd_idx != 3'd7) ? match_shadow[rd_idx] : `MPU_RST_WORD;
        end
      endcase
    end else begin
      reg_rdata <= `MPU_RST_WORD;
    end
  end

endmodule

`default_nettype wire

/* logic/mpu_map.vh */
// Register offsets, field positions and reset values of the match based modulator
`ifndef MPU_MAP_VH
`define MPU_MAP_VH

// Byte offsets of the register words
`define MPU_OFF_CTRL        8'h00
`define MPU_OFF_INT_STATUS  8'h04
`define MPU_OFF_INT_MASK    8'h08
`define MPU_OFF_COUNT       8'h0C
`define MPU_OFF_PRESCALE    8'h10
`define MPU_OFF_PRESC_COUNT 8'h14
`define MPU_OFF_MATCH_CTRL  8'h18
`define MPU_OFF_EDGE_SEL    8'h1C
`define MPU_OFF_OUT_EN      8'h20
`define MPU_OFF_RELEASE     8'h24
`define MPU_OFF_MATCH_BASE  8'h40
`define MPU_OFF_MATCH_LAST  8'h58

// Control word bit positions
`define MPU_CTRL_EN         0
`define MPU_CTRL_CRST       1
`define MPU_CTRL_PWM        2
`define MPU_CTRL_CNT_MODE   3
`define MPU_CTRL_CAP_SEL    4
`define MPU_CTRL_FOLLOW     5
`define MPU_CTRL_W          6

// Match control fields, seven bits each
`define MPU_MC_INT_LSB      0
`define MPU_MC_RST_LSB      8
`define MPU_MC_STOP_LSB     16

// Counts of match registers and outputs
`define MPU_N_MATCH         7
`define MPU_N_OUT           6

// Reset values
`define MPU_RST_CTRL        6'h00
`define MPU_RST_WORD        32'h0000_0000
`define MPU_RST_BITS7       7'h00
`define MPU_RST_BITS6       6'h00

`endif

/* logic/mpu_prescaler.v */
// Programmable prescaler that turns count source events into counter ticks
`default_nettype none

module mpu_prescaler (
  input  wire        core_clk,
  input  wire        srst,
  input  wire        run,
  input  wire        clear,
  input  wire        src_event,
  input  wire [31:0] limit,
  output wire        tick,
  output reg  [31:0] presc_count
);

  // Tick when the divider has seen limit+1 source events
  assign tick = run & ~clear & src_event & (presc_count == limit);

  // Divider counter, wraps on every tick
  always @(posedge core_clk) begin
    if (srst || clear) begin
      presc_count <= 32'h0000_0000;
    end else if (run && src_event) begin
      if (presc_count == limit) begin
        presc_count <= 32'h0000_0000;
      end else begin
        presc_count <= presc_count + 32'h0000_0001;
      end
    end
  end

endmodule

`default_nettype wire

/* logic/mpu_pwm_chan.v */
// Next level of one modulated output from its set and clear match events
`default_nettype none

module mpu_pwm_chan (
  input  wire level,
  input  wire dbl,
  input  wire period_hit,
  input  wire set_hit,
  input  wire clr_hit,
  output reg  next_level
);

  // Clear wins over set, so an edge at the period start gives constant low
  always @* begin
    next_level = level;
    if (clr_hit) begin
      next_level = 1'b0;
    end else if (dbl ? set_hit : period_hit) begin
      next_level = 1'b1;
    end
  end

endmodule

`default_nettype wire

/* testbench/mpu_top_asserts.sv */
// Port level checker for the match based modulator unit
`default_nettype none
`include "mpu_map.vh"
module mpu_top_asserts (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [1:0]  cap_in,
  input wire logic        sync_in,
  input wire logic        sync_out,
  input wire logic [5:0]  pwm_out,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic       pwm_on;  // Modulation enable as written
  logic       follow;  // Secondary mode as written
  logic [5:0] out_en;  // Output enables as written
  logic [6:0] mask;    // Interrupt mask as written
  wire        ctl_wr = reg_wr && reg_addr == `MPU_OFF_CTRL;
  wire        unmapped = reg_addr[1:0] != 2'h0 || reg_addr > `MPU_OFF_MATCH_LAST
    || (reg_addr > `MPU_OFF_RELEASE && reg_addr < `MPU_OFF_MATCH_BASE);
  // Copies of the bits that gate outputs and interrupt
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pwm_on <= 1'b0;
      follow <= 1'b0;
      out_en <= 6'h00;
      mask   <= 7'h00;
    end else if (reg_wr) begin
      if (ctl_wr) begin
        pwm_on <= reg_wdata[`MPU_CTRL_PWM];
        follow <= reg_wdata[`MPU_CTRL_FOLLOW];
      end
      if (reg_addr == `MPU_OFF_OUT_EN) out_en <= reg_wdata[5:0];
      if (reg_addr == `MPU_OFF_INT_MASK) mask <= reg_wdata[6:0];
    end
  end
  a_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000) else $error("stray read data");
  a_unmapped_zero:
    assert property ($past(reg_rd && unmapped) |-> reg_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
  a_reset_clears:
    assert property ($past(srst) |-> pwm_out == 6'h00 && !irq && !sync_out)
      else $error("outputs not cleared by reset");
  a_pwm_off:
    assert property (!pwm_on && !$past(pwm_on) |-> pwm_out == 6'h00)
      else $error("output active with modulation off");
  a_outen_gate:
    assert property ((pwm_out & ~out_en & ~$past(out_en)) == 6'h00)
      else $error("disabled output driven high");
  a_sync_start:
    assert property ($rose(sync_out) |-> $past(ctl_wr && reg_wdata[`MPU_CTRL_EN], 2))
      else $error("start level without enable write");
  a_irq_mask:
    assert property (irq |-> $past(mask) != 7'h00) else $error("interrupt while fully masked");
  a_hold_stopped:
    assert property (!follow && !$past(follow) && !$past(sync_out) && !$past(reg_wr, 2)
      |-> $stable(pwm_out)) else $error("output moved while stopped");
endmodule
bind mpu_top mpu_top_asserts mpu_top_asserts_i (.core_clk(core_clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cap_in(cap_in), .sync_in(sync_in), .sync_out(sync_out),
  .pwm_out(pwm_out), .irq(irq));
`default_nettype wire

/* testbench/mpu_load_model.sv */
// Loads on the modulated pins: measure high time and period
`default_nettype none
module mpu_load_model (
  input  wire logic        core_clk,
  input  wire logic [5:0]  pwm_out,
  output var  logic [15:0] high_len [6],
  output var  logic [15:0] period_len [6]
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] hi_cnt [6];   // High cycles this period
  logic [15:0] per_cnt [6];  // Cycles since last rise
  logic [5:0]  last;         // Previous pin levels
  // Latch both counts at every rising edge of a pin
  always_ff @(posedge core_clk) begin
    last <= pwm_out;
    for (int k = 0; k < 6; k++) begin
      if (pwm_out[k] && !last[k]) begin
        high_len[k]   <= hi_cnt[k];
        period_len[k] <= per_cnt[k];
        hi_cnt[k]     <= 16'h0001;
        per_cnt[k]    <= 16'h0001;
      end else begin
        hi_cnt[k]  <= hi_cnt[k] + {15'h0000, pwm_out[k]};
        per_cnt[k] <= per_cnt[k] + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/test_match_based_pwm_unit.sv */
// Self-checking bench for the match based modulator unit
`default_nettype none
`include "mpu_map.vh"
module test_match_based_pwm_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, srst, reg_wr, reg_rd, sync_in, sync_out, irq;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [1:0]  cap_in;
  logic [5:0]  pwm_out;
  logic [15:0] high_len [6];
  logic [15:0] period_len [6];
  int          mismatches, checks_done, p, ps, w, r, f, n;
  mpu_top mpu_top_i (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cap_in(cap_in), .sync_in(sync_in), .sync_out(sync_out), .pwm_out(pwm_out), .irq(irq));
  mpu_load_model mpu_load_model_i (.core_clk(core_clk), .pwm_out(pwm_out),
    .high_len(high_len), .period_len(period_len));
  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Print counts and verdict, then end
  task automatic report_and_stop();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Compare one result
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // One-cycle read, data taken in the next cycle
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Bounded wait for a level (sel 1 start level, else irq) or cnt rises on pin k
  task automatic wait_on(input int sel, input int k, input int cnt);
    int   t;
    logic prev;
    t = 0;
    prev = pwm_out[k];
    while (k >= 0 ? cnt > 0 : (sel ? sync_out : irq) !== cnt[0]) begin
      @(posedge core_clk);
      if (k >= 0 && pwm_out[k] === 1'b1 && prev !== 1'b1) cnt--;
      prev = pwm_out[k];
      t++;
      if (t > 3000) begin
        mismatches++;
        report_and_stop();
      end
    end
    #1;
  endtask
  // Expected high time of a two-edge output, in counts
  function automatic int dbl_high(int r, int f, int p);
    return (r < f) ? f - r : p + 1 - (r - f);
  endfunction
  initial begin
    {srst, reg_wr, reg_rd, sync_in, reg_addr, reg_wdata, cap_in} = '0;
    srst = 1'b1;
    n = $urandom(32'h2c98ca24);
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    // Reset values, then a misaligned address
    for (int a = 0; a < 8'h60; a += 4) begin
      rd(a[7:0]);
      chk("reset value", 32'h0000_0000, d);
    end
    rd(8'h41);
    chk("misaligned read", 32'h0000_0000, d);
    // Random period, prescale, single and two-edge outputs
    for (int i = 0; i < 3; i++) begin
      p  = 6 + $urandom % 6;
      ps = $urandom % 3;
      w  = 1 + $urandom % (p - 1);
      r  = (i == 0) ? p - 1 : 1 + $urandom % (p - 1);
      f  = (i == 0) ? 1 : 1 + (r + $urandom % (p - 2)) % (p - 1);
      wr(`MPU_OFF_CTRL, 32'h0000_0002);
      wr(`MPU_OFF_PRESCALE, ps);
      wr(`MPU_OFF_MATCH_BASE, p);
      wr(`MPU_OFF_MATCH_BASE + 8'h04, w);
      wr(`MPU_OFF_MATCH_BASE + 8'h08, r);
      wr(`MPU_OFF_MATCH_BASE + 8'h0C, f);
      wr(`MPU_OFF_EDGE_SEL, 32'h0000_0004);
      wr(`MPU_OFF_OUT_EN, 32'h0000_0005);
      wr(`MPU_OFF_RELEASE, 32'h0000_000F);
      wr(`MPU_OFF_CTRL, 32'h0000_0005);
      wait_on(0, 0, 3);
      chk("period", (p + 1) * (ps + 1), period_len[0]);
      chk("single high", (w + 1) * (ps + 1), high_len[0]);
      wait_on(0, 2, 2);
      chk("double high", dbl_high(r, f, p) * (ps + 1), high_len[2]);
    end
    // New width waits for its release
    n = w % (p - 1) + 1;
    wr(`MPU_OFF_MATCH_BASE + 8'h04, n);
    wait_on(0, 0, 3);
    chk("unreleased width", (w + 1) * (ps + 1), high_len[0]);
    wr(`MPU_OFF_RELEASE, 32'h0000_0002);
    wait_on(0, 0, 3);
    chk("released width", (n + 1) * (ps + 1), high_len[0]);
    // Timer mode: reset and interrupt on a match, then stop
    wr(`MPU_OFF_CTRL, 32'h0000_0002);
    wr(`MPU_OFF_PRESCALE, 32'h0000_0000);
    wr(`MPU_OFF_MATCH_BASE + 8'h0C, 32'h0000_0005);
    wr(`MPU_OFF_MATCH_CTRL, 32'h0000_0808);
    wr(`MPU_OFF_INT_MASK, 32'h0000_0008);
    wr(`MPU_OFF_RELEASE, 32'h0000_0008);
    wr(`MPU_OFF_CTRL, 32'h0000_0001);
    wait_on(0, -1, 1);
    rd(`MPU_OFF_INT_STATUS);
    chk("status", 32'h0000_0008, d);
    repeat (4) begin
      repeat ($urandom % 5) @(posedge core_clk);
      rd(`MPU_OFF_COUNT);
      chk("count bound", 32'h0000_0001, d <= 32'h0000_0005);
    end
    wr(`MPU_OFF_MATCH_CTRL, 32'h0008_0000);
    wait_on(1, -1, 0);
    rd(`MPU_OFF_COUNT);
    chk("stopped count", 32'h0000_0006, d);
    wr(`MPU_OFF_INT_MASK, 32'h0000_0000);
    // The level follows the new mask one edge after the write lands
    @(posedge core_clk);
    #1;
    chk("masked irq", 32'h0000_0000, irq);
    // Counter mode on capture input 0, noise on input 1
    wr(`MPU_OFF_MATCH_CTRL, 32'h0000_0000);
    wr(`MPU_OFF_CTRL, 32'h0000_000A);
    wr(`MPU_OFF_CTRL, 32'h0000_0009);
    n = 3 + $urandom % 5;
    repeat (n) begin
      repeat (2) @(posedge core_clk);
      cap_in <= {1'($urandom), 1'b1};
      repeat (2) @(posedge core_clk);
      cap_in <= {1'($urandom), 1'b0};
    end
    repeat (4) @(posedge core_clk);
    rd(`MPU_OFF_COUNT);
    chk("capture count", n, d);
    // Secondary waits for the start level
    wr(`MPU_OFF_CTRL, 32'h0000_0022);
    wr(`MPU_OFF_CTRL, 32'h0000_0021);
    repeat (5) @(posedge core_clk);
    rd(`MPU_OFF_COUNT);
    chk("secondary held", 32'h0000_0000, d);
    @(posedge core_clk);
    sync_in <= 1'b1;
    repeat (5) @(posedge core_clk);
    rd(`MPU_OFF_COUNT);
    chk("secondary runs", 32'h0000_0001, d != 32'h0000_0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
